// ### rtl/ulms_defines.svh
// Register offsets, field positions, reset values and tick counts of the serial port.
// Assumes inclusion by bare name from any file that needs them.
`ifndef ULMS_DEFINES_SVH
`define ULMS_DEFINES_SVH
`define ULMS_A_DATA 3'h0
`define ULMS_A_IEN 3'h1
`define ULMS_A_FIFO 3'h2
`define ULMS_A_FMT 3'h3
`define ULMS_A_MODEM 3'h4
`define ULMS_A_STAT 3'h5
`define ULMS_A_MSTAT 3'h6
`define ULMS_FMT_RST 8'h00
`define ULMS_MODEM_RST 8'h00
`define ULMS_IEN_RST 4'h0
`define ULMS_DIV_RST 16'h0001
`define ULMS_F_STOP 2
`define ULMS_F_PEN 3
`define ULMS_F_EPS 4
`define ULMS_F_STICK 5
`define ULMS_F_BRK 6
`define ULMS_F_DIVISOR_LATCH_SELECT 7
`define ULMS_M_DTR 0
`define ULMS_M_RTS 1
`define ULMS_M_USER_OUTPUT_FLAG 2
`define ULMS_M_GATE 3
`define ULMS_M_LOOP 4
`define ULMS_IE_RDA 0
`define ULMS_IE_THR 1
`define ULMS_IE_LSI 2
`define ULMS_T_HALF 5'h07
`define ULMS_T_BIT 5'h0f
`define ULMS_T_STOP1 5'h0f
`define ULMS_T_STOP15 5'h17
`define ULMS_T_STOP2 5'h1f
`endif

// ### rtl/ulms_pkg.sv
// Types shared by the serial-port line, modem and status logic.
// Assumes nothing of its surroundings.
package ulms_pkg;
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulms_rx_char_t;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK} ulms_rx_st_t;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} ulms_tx_st_t;
endpackage

// ### rtl/ulms_top.sv
// Serial port line format, modem control and line status, with receive FIFO.
// Assumes a synchronous CPU strobe bus and pin inputs synchronous to mclk.
// Function
// - Format bits 1:0 choose five to eight data bits.
// - Bit 2 gives 1.5 or 2 stop bits; receiver checks only the first.
// - Bit 3 enables parity, placed after data, before stop.
// - Bit 4 selects even parity, clear selects odd.
// - Bit 5 sticks parity to the inverse of bit 4.
// - Bit 6 forces serial output low until cleared, except in loopback.
// - Bit 7 steers offsets 0 and 1 to the divisor latches.
// - Modem bits 0 and 1 drive inverted ready and send-request pins.
// - Modem bit 2 is a pinless flag; bits 7:5 read zero.
// - Modem bit 3 enables the interrupt output, else it floats.
// - Loopback holds output at mark, loops shift data, parks modem pins high.
// - Loopback routes modem outputs onto the modem status inputs.
// - Data ready sets on a stored character, clears when all read.
// - Overrun sets at once when no room; FIFO mode drops the new character, else it replaces the unread one.
// - Parity error is tagged per character, shown at head, cleared on read.
// - Framing error on a zero stop bit, tagged, cleared on read.
// - After framing error the low level is taken as the next start.
// - Break when the line stays low a whole character, cleared on read.
// - Break stores one zero character; line must idle half a bit.
// - Any of status bits 1 to 4 raises the line status interrupt.
// - Holding empty sets on transfer, clears on write; all-empty when idle.
// - Status bit 7 flags errors in the FIFO, zero outside FIFO mode.
// - FIFO control bit 0 selects FIFO mode; clearing it empties the FIFO.
// - Interrupt-enable bit 2 gates the line status interrupt.
`timescale 1ns/100ps
`include "ulms_defines.svh"

module ulms_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end
endmodule // ulms_fifo

module ulms_top
  import ulms_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic rxd,
  input wire logic clear_to_send_in_n,
  input wire logic set_ready_in_n,
  input wire logic call_alert_in_n,
  input wire logic carrier_detect_in_n,
  output logic txd,
  output logic terminal_ready_out_n,
  output logic send_request_out_n,
  output logic irq_out,
  output logic irq_oe_n
);
  default clocking cb @(posedge mclk); endclocking

  // ---------------------------------------------------------------
  // Reset release and register bus
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  logic [7:0] fmt_q;
  logic [7:0] mdm_q;
  logic [3:0] ien_q;
  logic [15:0] div_q;
  logic fifo_mode_q;
  logic divisor_latch_select;
  logic loop;
  logic wr_thr;
  logic wr_div;
  logic rd_rbr;
  logic rd_lsr;
  logic fifo_flush;
  assign divisor_latch_select = fmt_q[`ULMS_F_DIVISOR_LATCH_SELECT];
  assign loop = mdm_q[`ULMS_M_LOOP];
  assign wr_thr = wr_en & (addr == `ULMS_A_DATA) & ~divisor_latch_select;
  assign rd_rbr = rd_en & (addr == `ULMS_A_DATA) & ~divisor_latch_select;
  assign wr_div = wr_en & ~addr[2] & ~addr[1] & divisor_latch_select;
  assign rd_lsr = rd_en & (addr == `ULMS_A_STAT);
  assign fifo_flush = wr_en & (addr == `ULMS_A_FIFO) & (~wdata[0] | wdata[1]);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_q <= `ULMS_FMT_RST;
      mdm_q <= `ULMS_MODEM_RST;
      ien_q <= `ULMS_IEN_RST;
      div_q <= `ULMS_DIV_RST;
      fifo_mode_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (addr)
        `ULMS_A_DATA:
          if (divisor_latch_select)
            div_q[7:0] <= wdata;
        `ULMS_A_IEN:
          if (divisor_latch_select)
            div_q[15:8] <= wdata;
          else
            ien_q <= wdata[3:0];
        `ULMS_A_FIFO: fifo_mode_q <= wdata[0];
        `ULMS_A_FMT: fmt_q <= wdata;
        `ULMS_A_MODEM: mdm_q <= {3'h0, wdata[4:0]};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sixteen-times baud tick
  // ---------------------------------------------------------------
  // A zero divisor runs at the same rate as one, so the port never stalls.
  // A latch write loads the value being written, so no long count of the old one follows.
  logic [15:0] bcnt_q;
  logic tick_q;
  logic [15:0] div_new;
  assign div_new = addr[0] ? {wdata, div_q[7:0]} : {div_q[15:8], wdata};
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcnt_q <= `ULMS_DIV_RST;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (bcnt_q <= `ULMS_DIV_RST) & ~wr_div;
      if (wr_div)
        bcnt_q <= div_new;
      else if (bcnt_q <= `ULMS_DIV_RST)
        bcnt_q <= div_q;
      else
        bcnt_q <= bcnt_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  ulms_tx_st_t tst_q;
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [7:0] tsr_q;
  logic [4:0] tcnt_q;
  logic [2:0] tbit_q;
  logic tline_q;
  logic xfer;
  logic [4:0] stop_end;
  logic [2:0] last_idx;
  logic tpar;
  assign last_idx = {1'b1, fmt_q[1:0]};
  assign xfer = (tst_q == T_IDLE) & hold_full_q;
  always_comb
  begin
    if (!fmt_q[`ULMS_F_STOP])
      stop_end = `ULMS_T_STOP1;
    else if (fmt_q[1:0] == 2'h0)
      stop_end = `ULMS_T_STOP15;
    else
      stop_end = `ULMS_T_STOP2;
  end
  // Data bits above the width are zero in the shift register, so a full xor is safe.
  assign tpar = fmt_q[`ULMS_F_STICK] ? ~fmt_q[`ULMS_F_EPS]
    : (^tsr_q) ^ ~fmt_q[`ULMS_F_EPS];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end
    else
    begin
      if (wr_thr)
        hold_q <= wdata;
      hold_full_q <= wr_thr | (hold_full_q & ~xfer);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_q <= T_IDLE;
      tsr_q <= 8'h00;
      tcnt_q <= 5'h00;
      tbit_q <= 3'h0;
      tline_q <= 1'b1;
    end
    else
    begin
      case (tst_q)
        T_IDLE:
          if (xfer)
          begin
            tsr_q <= hold_q & ~(8'hff << {1'b0, last_idx} << 1);
            tcnt_q <= 5'h00;
            tst_q <= T_START;
          end
        T_START:
        begin
          tline_q <= 1'b0;
          if (tick_q)
          begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == `ULMS_T_BIT)
            begin
              tcnt_q <= 5'h00;
              tbit_q <= 3'h0;
              tst_q <= T_DATA;
            end
          end
        end
        T_DATA:
        begin
          tline_q <= tsr_q[tbit_q];
          if (tick_q)
          begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == `ULMS_T_BIT)
            begin
              tcnt_q <= 5'h00;
              tbit_q <= tbit_q + 3'h1;
              if (tbit_q == last_idx)
                tst_q <= fmt_q[`ULMS_F_PEN] ? T_PAR : T_STOP;
            end
          end
        end
        T_PAR:
        begin
          tline_q <= tpar;
          if (tick_q)
          begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == `ULMS_T_BIT)
            begin
              tcnt_q <= 5'h00;
              tst_q <= T_STOP;
            end
          end
        end
        T_STOP:
        begin
          tline_q <= 1'b1;
          if (tick_q)
          begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == stop_end)
            begin
              tcnt_q <= 5'h00;
              tst_q <= T_IDLE;
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  ulms_rx_st_t rst_q;
  logic rxs;
  logic [7:0] rsr_q;
  logic [4:0] rcnt_q;
  logic [2:0] rbit_q;
  logic rpar_q;
  logic rzero_q;
  logic rx_push_q;
  ulms_rx_char_t rx_char_q;
  logic rxr_pe;
  assign rxs = loop ? tline_q : rxd;
  assign rxr_pe = fmt_q[`ULMS_F_STICK] ? (rpar_q != ~fmt_q[`ULMS_F_EPS])
    : ((^rsr_q) ^ rpar_q ^ ~fmt_q[`ULMS_F_EPS]);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q <= R_IDLE;
      rsr_q <= 8'h00;
      rcnt_q <= 5'h00;
      rbit_q <= 3'h0;
      rpar_q <= 1'b0;
      rzero_q <= 1'b1;
      rx_push_q <= 1'b0;
      rx_char_q <= '0;
    end
    else
    begin
      rx_push_q <= 1'b0;
      if (tick_q)
      begin
        rcnt_q <= rcnt_q + 5'h01;
        case (rst_q)
          R_IDLE:
          begin
            rcnt_q <= 5'h00;
            if (!rxs)
              rst_q <= R_START;
          end
          R_START:
            if (rcnt_q == `ULMS_T_HALF)
            begin
              rcnt_q <= 5'h00;
              rbit_q <= 3'h0;
              rsr_q <= 8'h00;
              rpar_q <= 1'b0;
              rzero_q <= 1'b1;
              rst_q <= rxs ? R_IDLE : R_DATA;
            end
          R_DATA:
            if (rcnt_q == `ULMS_T_BIT)
            begin
              rcnt_q <= 5'h00;
              rsr_q[rbit_q] <= rxs;
              rzero_q <= rzero_q & ~rxs;
              rbit_q <= rbit_q + 3'h1;
              if (rbit_q == last_idx)
                rst_q <= fmt_q[`ULMS_F_PEN] ? R_PAR : R_STOP;
            end
          R_PAR:
            if (rcnt_q == `ULMS_T_BIT)
            begin
              rcnt_q <= 5'h00;
              rpar_q <= rxs;
              rzero_q <= rzero_q & ~rxs;
              rst_q <= R_STOP;
            end
          R_STOP:
            // Only the first stop bit is looked at; further ones read as idle.
            if (rcnt_q == `ULMS_T_BIT)
            begin
              rcnt_q <= 5'h00;
              rx_push_q <= 1'b1;
              rx_char_q.data <= rsr_q;
              rx_char_q.pe <= fmt_q[`ULMS_F_PEN] & rxr_pe & ~(rzero_q & ~rxs);
              rx_char_q.fe <= ~rxs;
              rx_char_q.bi <= rzero_q & ~rxs;
              if (rxs)
                rst_q <= R_IDLE;
              else if (rzero_q)
              begin
                rx_char_q.data <= 8'h00;
                rst_q <= R_BRK;
              end
              else
                rst_q <= R_START;
            end
          R_BRK:
            if (!rxs)
              rcnt_q <= 5'h00;
            else if (rcnt_q == `ULMS_T_HALF)
              rst_q <= R_IDLE;
          default: rst_q <= R_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO and line status
  // ---------------------------------------------------------------
  ulms_rx_char_t head;
  logic head_valid;
  logic in_ready;
  logic can_push;
  logic head_seen_q;
  logic [2:0] err_cnt_q;
  logic st_oe_q;
  logic st_pe_q;
  logic st_fe_q;
  logic st_bi_q;
  logic head_new;
  logic push_err;
  logic pop_err;
  logic overrun;
  logic rx_pop;
  // Outside FIFO mode the FIFO acts as a single holding buffer: a new character pops
  // the unread one in the same cycle and takes its place.
  assign overrun = rx_push_q & (fifo_mode_q ? ~in_ready : (head_valid & ~rd_rbr));
  assign can_push = fifo_mode_q ? in_ready : 1'b1;
  assign rx_pop = rd_rbr | (overrun & ~fifo_mode_q);
  assign head_new = head_valid & ~head_seen_q & ~rx_pop;
  assign push_err = rx_push_q & can_push & (rx_char_q.pe | rx_char_q.fe | rx_char_q.bi);
  assign pop_err = rx_pop & head_valid & (head.pe | head.fe | head.bi);

  ulms_fifo #(.W($bits(ulms_rx_char_t)), .D(4)) u_rx_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(rx_push_q & can_push),
    .in_ready(in_ready),
    .in_data(rx_char_q),
    .out_valid(head_valid),
    .out_ready(rx_pop),
    .out_data(head)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_seen_q <= 1'b0;
      err_cnt_q <= 3'h0;
    end
    else if (fifo_flush)
    begin
      head_seen_q <= 1'b0;
      err_cnt_q <= 3'h0;
    end
    else
    begin
      head_seen_q <= (head_seen_q | head_new) & ~rx_pop;
      err_cnt_q <= err_cnt_q + 3'(push_err) - 3'(pop_err);
    end
  end

  // A new event in the cycle of a status read survives the read.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_oe_q <= 1'b0;
      st_pe_q <= 1'b0;
      st_fe_q <= 1'b0;
      st_bi_q <= 1'b0;
    end
    else
    begin
      st_oe_q <= overrun | (st_oe_q & ~rd_lsr);
      st_pe_q <= (head_new & head.pe) | (st_pe_q & ~rd_lsr);
      st_fe_q <= (head_new & head.fe) | (st_fe_q & ~rd_lsr);
      st_bi_q <= (head_new & head.bi) | (st_bi_q & ~rd_lsr);
    end
  end

  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic tx_holding_empty;
  assign tx_holding_empty = ~hold_full_q;
  assign lsr_val = {fifo_mode_q & (err_cnt_q != 3'h0), tx_holding_empty & (tst_q == T_IDLE), tx_holding_empty,
    st_bi_q, st_fe_q, st_pe_q, st_oe_q, head_valid};
  assign msr_val = loop
    ? {mdm_q[`ULMS_M_GATE], mdm_q[`ULMS_M_USER_OUTPUT_FLAG], mdm_q[`ULMS_M_DTR], mdm_q[`ULMS_M_RTS], 4'h0}
    : {~carrier_detect_in_n, ~call_alert_in_n, ~set_ready_in_n, ~clear_to_send_in_n, 4'h0};

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        `ULMS_A_DATA: rdata <= divisor_latch_select ? div_q[7:0] : head.data;
        `ULMS_A_IEN: rdata <= divisor_latch_select ? div_q[15:8] : {4'h0, ien_q};
        `ULMS_A_FIFO: rdata <= {fifo_mode_q, fifo_mode_q, 5'h00, ~irq_out};
        `ULMS_A_FMT: rdata <= fmt_q;
        `ULMS_A_MODEM: rdata <= mdm_q;
        `ULMS_A_STAT: rdata <= lsr_val;
        `ULMS_A_MSTAT: rdata <= msr_val;
        default: rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txd <= 1'b1;
      terminal_ready_out_n <= 1'b1;
      send_request_out_n <= 1'b1;
    end
    else
    begin
      txd <= loop | (tline_q & ~fmt_q[`ULMS_F_BRK]);
      terminal_ready_out_n <= loop | ~mdm_q[`ULMS_M_DTR];
      send_request_out_n <= loop | ~mdm_q[`ULMS_M_RTS];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_out <= 1'b0;
      irq_oe_n <= 1'b1;
    end
    else
    begin
      irq_out <= (ien_q[`ULMS_IE_LSI] & (st_oe_q | st_pe_q | st_fe_q | st_bi_q))
        | (ien_q[`ULMS_IE_RDA] & head_valid) | (ien_q[`ULMS_IE_THR] & tx_holding_empty);
      irq_oe_n <= ~mdm_q[`ULMS_M_GATE];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_break_holds_low: assert property (
    fmt_q[`ULMS_F_BRK] && !loop ##1 fmt_q[`ULMS_F_BRK] |-> !txd)
    else $error("break did not hold serial output low");
  a_loop_pins_high: assert property (
    loop ##1 loop |-> txd && terminal_ready_out_n && send_request_out_n)
    else $error("loopback did not park pins high");
  a_ready_pin_inverted: assert property (
    !loop && $stable(mdm_q) |=> terminal_ready_out_n != $past(mdm_q[`ULMS_M_DTR]))
    else $error("ready pin not inverse of its bit");
  a_irq_gate_float: assert property (!mdm_q[`ULMS_M_GATE] |=> irq_oe_n)
    else $error("interrupt driven while gate clear");
  a_overrun_sets: assert property (
    overrun |=> st_oe_q && ($stable(u_rx_fifo.cnt_q) || $past(rd_rbr) || $past(fifo_flush)))
    else $error("overrun not flagged or buffer count moved");
  a_status_read_clear: assert property (
    rd_lsr && !head_new && !rx_push_q |=> !st_pe_q && !st_fe_q && !st_bi_q && !st_oe_q)
    else $error("status read did not clear errors");
  a_ready_follows_fifo: assert property (
    rd_en && addr == `ULMS_A_STAT |=> rdata[0] == $past(head_valid))
    else $error("data ready disagrees with buffer");
  a_hold_write_busy: assert property (wr_thr |=> !tx_holding_empty)
    else $error("holding empty still set after write");
  a_modem_high_zero: assert property (
    rd_en && addr == `ULMS_A_MODEM |=> rdata[7:5] == 3'h0)
    else $error("modem control high bits not zero");
  a_bit7_nonfifo: assert property (!fifo_mode_q && rd_lsr |=> !rdata[7])
    else $error("status bit 7 set outside FIFO mode");
endmodule // ulms_top

// ### tb/tb_uart_line_modem_status.sv
// Self-checking bench for the serial port line, modem and status logic.
// Assumes divisor 1, so one bit is 16 mclk cycles.
`timescale 1ns/100ps
module tb_uart_line_modem_status;
  logic mclk, rst_b, wr_en, rd_en, ok, e;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, u, s;
  logic [7:0] c [5];
  logic [11:0] b, x;
  wire logic rxd, txd, tro, sro, irq_out, irq_oe_n;
  wire logic [3:0] mdm_n;
  wire logic [7:0] pn;
  integer seed, err_total, check_count, cyc, n;

  assign pn = {5'h00, tro, sro, irq_oe_n};
  always #2 mclk = ~mclk;

  ulms_top i_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd),
    .clear_to_send_in_n(mdm_n[0]), .set_ready_in_n(mdm_n[1]),
    .call_alert_in_n(mdm_n[2]), .carrier_detect_in_n(mdm_n[3]), .txd(txd),
    .terminal_ready_out_n(tro), .send_request_out_n(sro), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n));
  ulms_peer i_peer (.mclk(mclk), .txd(txd), .rxd(rxd), .mdm_n(mdm_n));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] x8);
    check_count++;
    if (g !== x8)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x8);
      err_total++;
    end
  endtask

  task automatic chf(input logic [11:0] g, input logic [11:0] xf);
    check_count++;
    if (g !== xf)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, xf);
      err_total++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr = a;
    rd_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
    d = rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] x8);
    logic [7:0] d;
    rd(a, d);
    chk(d, x8);
  endtask

  // Whole frame as sent on the wire, unused upper bits left at mark.
  function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d);
    int w;
    logic p;
    logic [11:0] r;
    w = 5 + f[1:0];
    r = 12'hfff;
    r[0] = 1'b0;
    p = ~f[4];
    for (int i = 0; i < w; i++)
    begin
      r[i + 1] = d[i];
      p ^= d[i];
    end
    if (f[5])
      p = ~f[4];
    if (f[3])
      r[w + 1] = p;
    return r;
  endfunction

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'h657edea5;
    {err_total, check_count, cyc} = '0;
    {mclk, rst_b, wr_en, rd_en, addr, wdata} = '0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    chk({7'h00, txd}, 8'h01);
    chk(pn, 8'h07);
    rdc(3'h3, 8'h00);
    rdc(3'h4, 8'h00);
    rdc(3'h5, 8'h60);
    rdc(3'h7, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      v[4] = 1'b0;
      wr(3'h4, v);
      rdc(3'h4, v & 8'h1f);
      chk(pn, {5'h00, ~v[0], ~v[1], ~v[3]});
    end
    wr(3'h3, 8'h03);
    i_peer.set_mdm(4'h5);
    rdc(3'h6, 8'ha0);
    i_peer.set_mdm(4'h0);
    wr(3'h4, 8'h1f);
    rdc(3'h6, 8'hf0);
    wr(3'h4, 8'h15);
    rdc(3'h6, 8'h60);
    chk(pn, 8'h07);
    wr(3'h0, 8'ha5);
    repeat (40) @(negedge mclk);
    chk({7'h00, txd}, 8'h01);
    repeat (200) @(negedge mclk);
    rdc(3'h0, 8'ha5);
    wr(3'h4, 8'h08);
    wr(3'h3, 8'h43);
    repeat (2) @(negedge mclk);
    chk({7'h00, txd}, 8'h00);
    wr(3'h1, 8'h04);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h5a);
    wr(3'h1, 8'h3c);
    rdc(3'h0, 8'h5a);
    rdc(3'h1, 8'h3c);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rdc(3'h1, 8'h04);
    for (int f = 0; f < 64; f++)
    begin
      wr(3'h3, 8'(f));
      n = 7 + f[1:0] + f[3];
      v = 8'($random(seed));
      wr(3'h0, v);
      i_peer.grab(n, b, ok);
      chk({7'h00, ok}, 8'h01);
      chf(b, frm(8'(f), v));
      u = 8'($random(seed));
      e = f[3] & v[0];
      x = frm(8'(f), u);
      x[n - 2] = x[n - 2] ^ e;
      i_peer.send(x, n);
      chk({7'h00, irq_out}, {7'h00, e});
      rd(3'h5, s);
      chk(s & 8'h1f, {5'h00, e, 2'b01});
      rdc(3'h0, u & (8'hff >> (2'd3 - f[1:0])));
      rd(3'h5, s);
      chk(s & 8'h1f, 8'h00);
      chk({7'h00, irq_out}, 8'h00);
    end
    wr(3'h3, 8'h03);
    i_peer.send(12'h000, 11);
    rd(3'h5, s);
    chk(s & 8'h13, 8'h11);
    rdc(3'h0, 8'h00);
    x = frm(8'h03, 8'h3c);
    x[9] = 1'b0;
    i_peer.send(x, 10);
    rdc(3'h5, 8'h69);
    rdc(3'h0, 8'h3c);
    for (int k = 0; k < 5; k++)
      c[k] = 8'($random(seed));
    i_peer.send(frm(8'h03, c[0]), 10);
    i_peer.send(frm(8'h03, c[1]), 10);
    rd(3'h5, s);
    chk(s & 8'h03, 8'h03);
    rdc(3'h0, c[1]);
    rdc(3'h5, 8'h60);
    wr(3'h2, 8'h01);
    rdc(3'h2, 8'hc1);
    wr(3'h3, 8'h1b);
    for (int k = 0; k < 5; k++)
    begin
      x = frm(8'h1b, c[k]);
      x[9] = x[9] ^ (k == 0);
      i_peer.send(x, 11);
    end
    rdc(3'h5, 8'he7);
    rdc(3'h0, c[0]);
    rdc(3'h5, 8'h61);
    rdc(3'h0, c[1]);
    wr(3'h2, 8'h00);
    rdc(3'h5, 8'h60);
    rdc(3'h2, 8'h01);
    wr(3'h1, 8'h02);
    repeat (2) @(negedge mclk);
    chk({7'h00, irq_out}, 8'h01);
    wr(3'h1, 8'h01);
    repeat (2) @(negedge mclk);
    chk({7'h00, irq_out}, 8'h00);
    wrap_up();
  end
endmodule // tb_uart_line_modem_status

// ### tb/ulms_peer.sv
// Serial peer on the line side: drives the receive line and modem inputs.
// Assumes its tasks are called from the falling edge of mclk, divisor 1.
`timescale 1ns/100ps
module ulms_peer (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd,
  output logic [3:0] mdm_n
);
  initial
  begin
    rxd = 1'b1;
    mdm_n = 4'hf;
  end

  task automatic set_mdm(input logic [3:0] v);
    mdm_n = v;
  endtask

  // Bits go out LSB first, 16 ticks each; idle afterwards is long enough to restart.
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd = b[i];
      repeat (16) @(negedge mclk);
    end
    rxd = 1'b1;
    repeat (32) @(negedge mclk);
  endtask

  task automatic grab(input int n, output logic [11:0] b, output logic ok);
    int k;
    b = 12'hfff;
    k = 0;
    while (txd !== 1'b0 && k < 400)
    begin
      k++;
      @(negedge mclk);
    end
    ok = (k < 400);
    repeat (8) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      b[i] = txd;
      repeat (16) @(negedge mclk);
    end
  endtask
endmodule // ulms_peer
